// ==== hdl/phybcr_pkg.sv ====
// phybcr_pkg: constants for the phy basic control register block
// assumes a 32-bit axi4-lite register bus, one word per register
package phybcr_pkg;
    // management space
    localparam int REG_COUNT = 32;
    localparam int STD_COUNT = 16;
    localparam logic [6:0] REG_INDEX_BASIC_CONTROL = 7'h00;
    localparam logic [11:0] ADDR_BASIC_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_STRAP_STATUS = 12'h080;
    localparam logic [11:0] ADDR_PHY_STATE = 12'h084;
    // field positions in basic_control
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED_100 = 13;
    localparam int BIT_AUTONEG_EN = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AUTONEG_RESTART = 9;
    // reset values of non-strap bits
    localparam logic RST_LOOPBACK = 1'b0;
    localparam logic RST_POWER_DOWN = 1'b0;
    // chip reset pulse length
    localparam int CHIP_RESET_NS = 400;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CHIP_RESET_CYCLES = (CHIP_RESET_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_RELATCH} phybcr_state_t;
endpackage : phybcr_pkg

// ==== hdl/phybcr_strap.sv ====
// phybcr_strap: captures strap pin levels on request
// assumes strap pins are stable and synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module phybcr_strap
    import phybcr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // capture request
    input wire logic capture,
    // strap pins
    input wire logic autoneg_enable_strap,
    input wire logic speed_strap,
    input wire logic isolate_strap,
    // latched values
    output logic an_latched,
    output logic speed_latched,
    output logic iso_latched
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            an_latched <= 1'b0;
            speed_latched <= 1'b0;
            iso_latched <= 1'b0;
        end else if (capture) begin
            an_latched <= autoneg_enable_strap;
            speed_latched <= speed_strap;
            iso_latched <= isolate_strap;
        end
    end
endmodule : phybcr_strap
`default_nettype wire

// ==== hdl/phybcr_top.sv ====
// phybcr_top: basic control register of a 10/100 phy over axi4-lite
// assumes a single 25 mhz clock and synchronous strap inputs
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Function
// - 32 management registers; 0..15 standard, 16..31 vendor, all reachable.
// - bit 15 write of 1 resets the phy, self-clears, reads 0.
// - bit 13 forces 100 when 1, 10 when 0; ignored under autoneg.
// - bit 12 enables autoneg; negotiated result overrides speed and duplex.
// - autoneg enable default comes from latched autoneg strap.
// - speed select default comes from latched speed strap.
// - bit 11 set enters power-down, clear restores; default 0.
// - soft reset outside power-down resets chip and relatches straps.
// - bit 10 isolates mac-side interface; default from isolate strap.
// - bit 9 write of 1 restarts autoneg, self-clears, default 0.
module phybcr_top
    import phybcr_pkg::*;
#(
    parameter int RESET_CYCLES = CHIP_RESET_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // strap pins
    input wire logic autoneg_enable_strap,
    input wire logic speed_strap,
    input wire logic isolate_strap,
    // negotiated result and manual duplex
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic manual_full_duplex,
    // phy controls
    output logic chip_reset,
    output logic loopback_en,
    output logic autoneg_en,
    output logic autoneg_restart,
    output logic power_down,
    output logic isolate,
    output logic speed_100,
    output logic full_duplex
);
    // refuse reset lengths the 16-bit counter cannot hold
    if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin : g_bad_len
        $error("RESET_CYCLES out of range");
    end

    phybcr_state_t state_r, state_nxt;
    logic [15:0] rst_cnt_r, rst_cnt_nxt;
    logic loop_r, an_r, spd_r, pd_r, iso_r, restart_r;
    logic aw_hold_r, w_hold_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic an_l, spd_l, iso_l;
    logic load_r;

    // capture on release of reset and at end of chip reset
    logic capture;
    logic first_r;
    assign capture = first_r || (state_r == ST_RELATCH);

    phybcr_strap u_strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .capture(capture),
        .autoneg_enable_strap(autoneg_enable_strap),
        .speed_strap(speed_strap),
        .isolate_strap(isolate_strap),
        .an_latched(an_l),
        .speed_latched(spd_l),
        .iso_latched(iso_l)
    );

    function automatic logic in_space(input logic [11:0] a);
        in_space = (a[1:0] == 2'b00) && (a[11:7] == 5'h00);
    endfunction : in_space

    // write path: address and data in either order
    wire aw_take = s_axi_awvalid && !aw_hold_r;
    wire w_take = s_axi_wvalid && !w_hold_r;
    wire have_aw = aw_hold_r || s_axi_awvalid;
    wire have_w = w_hold_r || s_axi_wvalid;
    wire [11:0] wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
    // no writes while straps reload, else the load would swallow them
    wire busy = (state_r != ST_IDLE) || capture || load_r;
    wire wr_fire = have_aw && have_w && !bvalid_r && !busy;
    wire wr_ok = in_space(wr_addr);
    wire wr_ctl = wr_fire && (wr_addr == ADDR_BASIC_CONTROL);
    wire hi_en = wr_strb[1];
    wire lo_en = wr_strb[0];
    wire soft_rst = wr_ctl && hi_en && wr_data[BIT_SOFT_RESET];

    assign s_axi_awready = !aw_hold_r && !bvalid_r && !busy;
    assign s_axi_wready = !w_hold_r && !bvalid_r && !busy;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // read path
    wire rd_fire = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    wire [15:0] ctl_word = {1'b0, loop_r, spd_r, an_r, pd_r, iso_r,
        restart_r, 9'h000};
    wire [31:0] rd_word =
        (s_axi_araddr == ADDR_BASIC_CONTROL) ? {16'h0000, ctl_word} :
        (s_axi_araddr == ADDR_STRAP_STATUS) ?
            {29'h0000_0000, iso_l, spd_l, an_l} :
        (s_axi_araddr == ADDR_PHY_STATE) ?
            {30'h0000_0000, state_r != ST_IDLE, pd_r} :
        32'h0000_0000;
    wire rd_ok = in_space(s_axi_araddr);

    // reset sequencer
    always_comb begin
        state_nxt = state_r;
        rst_cnt_nxt = rst_cnt_r;
        case (state_r)
            ST_IDLE: begin
                // out of power-down first, reset only when already up
                if (soft_rst && !pd_r) begin
                    state_nxt = ST_RESET;
                    rst_cnt_nxt = 16'(RESET_CYCLES - 1);
                end
            end
            ST_RESET: begin
                if (rst_cnt_r == 16'h0000) begin
                    state_nxt = ST_RELATCH;
                end else begin
                    rst_cnt_nxt = rst_cnt_r - 16'h0001;
                end
            end
            ST_RELATCH: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            rst_cnt_r <= 16'h0000;
            first_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            first_r <= 1'b0;
        end
    end

    // control bits; strap defaults load one cycle after capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_r <= 1'b0;
        end else begin
            load_r <= capture;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_r <= RST_LOOPBACK;
            an_r <= 1'b0;
            spd_r <= 1'b0;
            pd_r <= RST_POWER_DOWN;
            iso_r <= 1'b0;
            restart_r <= 1'b0;
        end else if (load_r) begin
            loop_r <= RST_LOOPBACK;
            an_r <= an_l;
            spd_r <= spd_l;
            pd_r <= RST_POWER_DOWN;
            iso_r <= iso_l;
            restart_r <= 1'b0;
        end else if (state_r == ST_RESET) begin
            restart_r <= 1'b0;
        end else if (soft_rst && pd_r) begin
            pd_r <= 1'b0;
            restart_r <= 1'b0;
        end else if (wr_ctl && hi_en) begin
            loop_r <= wr_data[BIT_LOOPBACK];
            spd_r <= wr_data[BIT_SPEED_100];
            an_r <= wr_data[BIT_AUTONEG_EN];
            pd_r <= wr_data[BIT_POWER_DOWN];
            iso_r <= wr_data[BIT_ISOLATE];
            restart_r <= wr_data[BIT_AUTONEG_RESTART];
        end else begin
            restart_r <= 1'b0;
        end
    end

    // bus handshake registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take && s_axi_awready) begin
                    aw_hold_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_take && s_axi_wready) begin
                    w_hold_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb_r <= s_axi_wstrb;
                end
                if (bvalid_r && s_axi_bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // phy-facing outputs
    logic lo_unused;
    assign lo_unused = lo_en;
    assign chip_reset = (state_r == ST_RESET);
    assign loopback_en = loop_r;
    assign autoneg_en = an_r;
    assign autoneg_restart = restart_r;
    assign power_down = pd_r;
    assign isolate = iso_r;
    assign speed_100 = an_r ? an_speed_100 : spd_r;
    assign full_duplex = an_r ? an_full_duplex : manual_full_duplex;

    // checks
    a_reset_selfclr: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_rdata[BIT_SOFT_RESET])
        else $error("soft reset bit read as one");
    a_speed_forced: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !autoneg_en |-> speed_100 == spd_r)
        else $error("forced speed not applied");
    a_autoneg_wins: assert property (
        @(posedge aclk) disable iff (!aresetn)
        autoneg_en |-> speed_100 == an_speed_100 &&
        full_duplex == an_full_duplex)
        else $error("negotiated result not used");
    a_strap_an: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(load_r) |-> autoneg_en == an_l)
        else $error("autoneg default not from strap");
    a_strap_speed: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(load_r) |=> spd_r == spd_l)
        else $error("speed default not from strap");
    a_pd_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_ctl && hi_en && !soft_rst && state_r == ST_IDLE && !load_r
        |=> power_down == $past(wr_data[BIT_POWER_DOWN]))
        else $error("power-down write lost");
    a_pd_exit: assert property (
        @(posedge aclk) disable iff (!aresetn)
        soft_rst && power_down && !load_r |=> !power_down && !chip_reset)
        else $error("first reset write did not leave power-down");
    a_chip_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        soft_rst && !power_down |=> chip_reset)
        else $error("chip reset not started");
    a_iso_strap: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(load_r) |=> isolate == iso_l)
        else $error("isolate default not from strap");
    a_restart_pulse: assert property (
        @(posedge aclk) disable iff (!aresetn)
        autoneg_restart |=> !autoneg_restart)
        else $error("restart bit did not self-clear");
    a_loop_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_ctl && hi_en && !soft_rst && state_r == ST_IDLE && !load_r
        |=> loopback_en == $past(wr_data[BIT_LOOPBACK]))
        else $error("loopback write lost");
endmodule : phybcr_top
`default_nettype wire

// ==== verif/phybcr_mgmt_model.sv ====
// phybcr_mgmt_model: axi4-lite master acting as the management controller
// assumes its tasks are called from the bench's single main process
`timescale 1ns/10ps
`default_nettype none
module phybcr_mgmt_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    localparam int WAIT_MAX = 200;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // payload turned round on release so stale values never look valid
    task automatic write(input logic [11:0] addr, input logic [31:0] data,
            output logic [1:0] resp, output logic ok);
        int n;
        ok = 1'b0;
        resp = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < WAIT_MAX && !ok; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask : write
    task automatic read(input logic [11:0] addr, output logic [31:0] data,
            output logic [1:0] resp, output logic ok);
        int n;
        ok = 1'b0;
        resp = 2'b11;
        data = '0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < WAIT_MAX && !ok; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask : read
endmodule : phybcr_mgmt_model
`default_nettype wire

// ==== verif/tb.sv ====
// tb: self-checking bench for the phy basic control register
// assumes phybcr_mgmt_model is the only master on the register bus
`timescale 1ns/10ps
`default_nettype none
module tb
    import phybcr_pkg::*;
;
    localparam int RST_LEN = 3;
    typedef struct packed {
        logic [2:0] neg;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [5:0] outs;
    } phybcr_row_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic arvalid, arready, rvalid, rready;
    logic an_strap, speed_strap, iso_strap, an_spd, an_fd, man_fd;
    logic chip_reset, loopback_en, autoneg_en, autoneg_restart;
    logic power_down, isolate, speed_100, full_duplex;
    int n_fail, check_count, n_restart, chip_cycles;
    wire [5:0] outs = {loopback_en, speed_100, autoneg_en, power_down,
        isolate, full_duplex};
    // negotiated inputs as {speed, duplex, manual duplex}
    phybcr_row_t rows [9] = '{
        '{3'b110, 16'h4000, 16'h4000, 6'h20},
        '{3'b110, 16'h2000, 16'h2000, 6'h10},
        '{3'b110, 16'h0000, 16'h0000, 6'h00},
        '{3'b110, 16'h1000, 16'h1000, 6'h19},
        '{3'b110, 16'h0400, 16'h0400, 6'h02},
        '{3'b110, 16'h0200, 16'h0000, 6'h00},
        '{3'b001, 16'h3000, 16'h3000, 6'h08},
        '{3'b001, 16'h0000, 16'h0000, 6'h01},
        '{3'b110, 16'h0800, 16'h0800, 6'h04}};
    logic [11:0] addrs [5] = '{12'h004, 12'h07c, 12'h002, 12'h080, 12'h100};
    logic [1:0] resps [5] = '{RESP_OKAY, RESP_OKAY, RESP_SLVERR,
        RESP_SLVERR, RESP_SLVERR};
    phybcr_top #(.RESET_CYCLES(RST_LEN)) i_dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .autoneg_enable_strap(an_strap),
        .speed_strap(speed_strap), .isolate_strap(iso_strap),
        .an_speed_100(an_spd), .an_full_duplex(an_fd),
        .manual_full_duplex(man_fd), .chip_reset(chip_reset),
        .loopback_en(loopback_en), .autoneg_en(autoneg_en),
        .autoneg_restart(autoneg_restart), .power_down(power_down),
        .isolate(isolate), .speed_100(speed_100), .full_duplex(full_duplex));
    phybcr_mgmt_model i_mgmt (.aclk(aclk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // restart pulses and chip reset cycles seen at the outputs
    always_ff @(posedge aclk) begin
        if (autoneg_restart === 1'b1) n_restart <= n_restart + 1;
        if (chip_reset === 1'b1) chip_cycles <= chip_cycles + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [11:0] a, input logic [15:0] d,
            input logic [1:0] er);
        logic [1:0] r;
        logic ok;
        i_mgmt.write(a, {16'h0000, d}, r, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        check({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
            input logic [1:0] er);
        logic [1:0] r;
        logic ok;
        i_mgmt.read(a, d, r, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        check({30'h0, r}, {30'h0, er});
    endtask : rd
    // straps as {autoneg, speed, isolate}
    task automatic reset_check(input logic [2:0] s);
        logic [31:0] d;
        logic [31:0] e;
        aresetn <= 1'b0;
        {an_strap, speed_strap, iso_strap} <= s;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(12'h000, d, RESP_OKAY);
        e = {16'h0000, 2'b00, s[1], s[2], 1'b0, s[0], 10'h000};
        check(d, e);
        e = {26'h0, 1'b0, s[2] | s[1], s[2], 1'b0, s[0], s[2]};
        check({26'h0, outs}, e);
    endtask : reset_check
    initial begin
        logic [31:0] d;
        logic [31:0] e;
        int n;
        aresetn = 1'b0;
        {an_strap, speed_strap, iso_strap} = 3'b101;
        {an_spd, an_fd, man_fd} = 3'b110;
        reset_check(3'b101);
        for (int i = 0; i < 9; i++) begin
            {an_spd, an_fd, man_fd} <= rows[i].neg;
            wr(12'h000, rows[i].wdata, RESP_OKAY);
            rd(12'h000, d, RESP_OKAY);
            e = {16'h0000, rows[i].rdata};
            check(d, e);
            e = {26'h0, rows[i].outs};
            check({26'h0, outs}, e);
        end
        check(n_restart, 1);
        {an_strap, speed_strap, iso_strap} <= 3'b010;
        wr(12'h000, 16'h8000, RESP_OKAY);
        check({31'h0, power_down}, 32'h0);
        check(chip_cycles, 0);
        wr(12'h000, 16'h8000, RESP_OKAY);
        n = 0;
        while (n < 50 && (chip_reset !== 1'b0 || chip_cycles < RST_LEN)) begin
            n++;
            @(posedge aclk);
        end
        if (n == 50) begin
            n_fail++;
            stop_test();
        end
        repeat (3) @(posedge aclk);
        check(chip_cycles, RST_LEN);
        rd(12'h000, d, RESP_OKAY);
        check(d, 32'h0000_2000);
        for (int i = 0; i < 5; i++) begin
            wr(addrs[i], 16'hffff, resps[i]);
            rd(addrs[i], d, resps[i]);
        end
        rd(12'h000, d, RESP_OKAY);
        check(d, 32'h0000_2000);
        reset_check(3'b011);
        stop_test();
    end
endmodule : tb
`default_nettype wire
